//--- hw/dop_defs.svh
// constants of the dual-channel output and power control block
// assumes: included by dop_pkg and the design modules by bare name
// ********************************************************************
// How it works
// - output disable high floats that channel's bus; channel A's also floats the flag
// - one output disable per channel, own outputs
// - power-down low means normal conversion
// - power-down and disable high means sleep
// - power-down high, disable low means nap
// - data valid about 100 clocks after nap
// - nap and sleep float that channel's bus; A's also floats the flag, B's the data ready clock
// - each channel decoded from its own pins
// - swap select high: straight bus routing
// - swap select low: buses exchanged
// - shared overflow flag, off when channel A idle
// - data ready clock follows B clock, off when idle
// ********************************************************************
`ifndef DOP_DEFS_SVH
`define DOP_DEFS_SVH

`define DOP_DATA_W 10
`define DOP_ADDR_W 12

// register offsets (byte addresses)
`define DOP_CTRL_OFS 12'h000
`define DOP_STATUS_OFS 12'h004

// control fields
`define DOP_CTRL_FDIS_A 0
`define DOP_CTRL_FDIS_B 1
`define DOP_CTRL_W 2
`define DOP_CTRL_RST 2'h0

// status fields
`define DOP_STAT_NAP_A 0
`define DOP_STAT_SLEEP_A 1
`define DOP_STAT_VALID_A 2
`define DOP_STAT_NAP_B 3
`define DOP_STAT_SLEEP_B 4
`define DOP_STAT_VALID_B 5
`define DOP_STAT_W 6
`define DOP_STAT_RST 6'h00

// timing
`define DOP_NAP_RECOV_CYC 100
`define DOP_SLEEP_RECOV_NS 1000000
`define DOP_LINK_PERIOD_NS 64

`endif

//--- hw/dop_pkg.sv
// types shared by the output and power control modules
// assumes: dop_defs.svh on the include path
`include "dop_defs.svh"

package dop_pkg;

  // ******************************************************************
  // channel power modes
  // ******************************************************************
  typedef enum logic [1:0] {MODE_NORMAL, MODE_NAP, MODE_SLEEP} dop_mode_t;

  // ******************************************************************
  // carriers
  // ******************************************************************
  typedef struct packed {
    logic power_down;
    logic output_disable;
  } dop_pins_t;

  typedef struct packed {
    logic over;
    logic [`DOP_DATA_W-1:0] data;
  } dop_sample_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [`DOP_ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } dop_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } dop_apb_rsp_t;

endpackage : dop_pkg

//--- hw/dop_sync.sv
// level synchroniser: three flops, output follows once stages two and three agree
// assumes: input is a level from another clock domain or a pin
`timescale 1ns/10ps
`include "dop_defs.svh"

module dop_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  import dop_pkg::*;

  logic [W-1:0] s1_reg, s2_reg, s3_reg, q_reg;
  logic [W-1:0] q_next;

  if (W < 1) begin : g_chk
    $error("dop_sync: W must be at least 1");
  end

  // s1 feeds only s2; the agreement filter looks at s2 and s3
  always_comb begin
    q_next = q_reg;
    if (s2_reg == s3_reg) begin
      q_next = s3_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_reg <= INIT;
      s2_reg <= INIT;
      s3_reg <= INIT;
      q_reg <= INIT;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      q_reg <= q_next;
    end
  end

  assign q = q_reg;

endmodule : dop_sync

//--- hw/dop_chan.sv
// one channel's power mode decode and data recovery timing
// assumes: pins already synchronised to the sample clock domain
`timescale 1ns/10ps
`include "dop_defs.svh"

module dop_chan #(
  parameter int NAP_CYC = `DOP_NAP_RECOV_CYC,
  parameter int SLEEP_CYC = 15625,
  parameter int CW = 16
) (
  input wire logic lclk,
  input wire logic lrst_n,
  input wire dop_pkg::dop_pins_t pins,
  output dop_pkg::dop_mode_t mode,
  output logic drive_en,
  output logic data_valid
);
  import dop_pkg::*;

  dop_mode_t mode_reg, mode_next;
  logic [CW-1:0] wait_reg, wait_next;
  logic drive_reg, drive_next;

  if (NAP_CYC < 1 || SLEEP_CYC < 1 || SLEEP_CYC >= (1 << CW) || NAP_CYC >= (1 << CW))
  begin : g_chk
    $error("dop_chan: recovery counts must fit the counter");
  end

  // ******************************************************************
  // mode decode and recovery count
  // ******************************************************************
  always_comb begin
    // plain level decode, nothing edge triggered
    if (!pins.power_down) begin
      mode_next = MODE_NORMAL;
    end else if (pins.output_disable) begin
      mode_next = MODE_SLEEP;
    end else begin
      mode_next = MODE_NAP;
    end
    wait_next = wait_reg;
    if (mode_next != MODE_NORMAL) begin
      wait_next = '0;
    end else if (mode_reg == MODE_NAP) begin
      wait_next = CW'(NAP_CYC);
    end else if (mode_reg == MODE_SLEEP) begin
      wait_next = CW'(SLEEP_CYC);
    end else if (wait_reg != '0) begin
      wait_next = wait_reg - CW'(1);
    end
    // floated in nap, sleep or when disabled
    drive_next = (mode_next == MODE_NORMAL) && !pins.output_disable;
  end

  // reset parks the channel floated until the pins are seen
  always_ff @(posedge lclk) begin
    if (!lrst_n) begin
      mode_reg <= MODE_SLEEP;
      wait_reg <= '0;
      drive_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      wait_reg <= wait_next;
      drive_reg <= drive_next;
    end
  end

  assign mode = mode_reg;
  assign drive_en = drive_reg;
  assign data_valid = (mode_reg == MODE_NORMAL) && (wait_reg == '0);

endmodule : dop_chan

//--- hw/dop_top.sv
// dual-channel converter output stage: power modes, bus swap, tri-state control
// assumes: both sample clocks tied to one source, fed in as chan_b_sample_clock;
// conversion results arrive already timed to that clock; apb on clk
`timescale 1ns/10ps
`include "dop_defs.svh"

module dop_top #(
  parameter int SLEEP_RECOV_CYC =
    (`DOP_SLEEP_RECOV_NS + `DOP_LINK_PERIOD_NS - 1) / `DOP_LINK_PERIOD_NS,
  parameter int NAP_RECOV_CYC = `DOP_NAP_RECOV_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire dop_pkg::dop_apb_req_t apb_req,
  output dop_pkg::dop_apb_rsp_t apb_rsp,
  input wire logic chan_b_sample_clock,
  input wire logic chan_a_power_down,
  input wire logic chan_a_output_disable,
  input wire logic chan_b_power_down,
  input wire logic chan_b_output_disable,
  input wire logic bus_swap_select,
  input wire dop_pkg::dop_sample_t chan_a_result,
  input wire dop_pkg::dop_sample_t chan_b_result,
  output logic [`DOP_DATA_W-1:0] bus_a_data,
  output logic bus_a_data_oe,
  output logic [`DOP_DATA_W-1:0] bus_b_data,
  output logic bus_b_data_oe,
  output logic range_overflow_flag,
  output logic range_overflow_flag_oe,
  output logic data_ready_clock,
  output logic data_ready_clock_oe
);
  import dop_pkg::*;

  localparam int DW = `DOP_DATA_W;

  if (SLEEP_RECOV_CYC < 1 || NAP_RECOV_CYC < 1 || SLEEP_RECOV_CYC > 65535) begin : g_chk
    $error("dop_top: recovery counts out of range");
  end

  // ******************************************************************
  // link domain reset
  // ******************************************************************
  // reset enters the sample clock domain through its own three flops;
  // the sample clock must run while nrst is low for the link side to reset
  logic lrst_s1_reg, lrst_s2_reg, lrst_s3_reg, lrst_n_reg;
  logic lrst_n_next;

  always_comb begin
    lrst_n_next = lrst_n_reg;
    if (lrst_s2_reg == lrst_s3_reg) begin
      lrst_n_next = lrst_s3_reg;
    end
  end

  always_ff @(posedge chan_b_sample_clock) begin
    lrst_s1_reg <= nrst;
    lrst_s2_reg <= lrst_s1_reg;
    lrst_s3_reg <= lrst_s2_reg;
    lrst_n_reg <= lrst_n_next;
  end

  // ******************************************************************
  // apb register slave
  // ******************************************************************
  logic [`DOP_CTRL_W-1:0] ctrl_reg, ctrl_next;
  dop_apb_rsp_t rsp_reg, rsp_next;
  logic [`DOP_STAT_W-1:0] stat_sync;
  logic access;

  assign access = apb_req.psel && apb_req.penable;

  // one wait state: pready rises at the end of the first access cycle, the transfer
  // completes on the next edge and pready drops again
  always_comb begin
    ctrl_next = ctrl_reg;
    rsp_next = rsp_reg;
    rsp_next.pready = 1'b0;
    if (access && !rsp_reg.pready) begin
      rsp_next.pready = 1'b1;
      rsp_next.pslverr = 1'b0;
      rsp_next.prdata = 32'h0000_0000;
      case (apb_req.paddr)
        `DOP_CTRL_OFS: begin
          rsp_next.prdata[`DOP_CTRL_W-1:0] = ctrl_reg;
        end
        `DOP_STATUS_OFS: begin
          rsp_next.prdata[`DOP_STAT_W-1:0] = stat_sync;
        end
        default: begin
          rsp_next.pslverr = 1'b1;
        end
      endcase
    end
    if (access && rsp_reg.pready && apb_req.pwrite && apb_req.paddr == `DOP_CTRL_OFS) begin
      ctrl_next = apb_req.pwdata[`DOP_CTRL_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctrl_reg <= `DOP_CTRL_RST;
      rsp_reg <= '0;
    end else begin
      ctrl_reg <= ctrl_next;
      rsp_reg <= rsp_next;
    end
  end

  assign apb_rsp = rsp_reg;

  // ******************************************************************
  // crossings
  // ******************************************************************
  logic [4:0] pin_sync;
  logic [`DOP_CTRL_W-1:0] ctrl_sync;
  logic [`DOP_STAT_W-1:0] stat_link_reg, stat_link_next;

  // pins start as powered down and disabled, swap high (straight)
  dop_sync #(.W(5), .INIT(5'h1f)) u_pin_sync (
    .clk(chan_b_sample_clock),
    .rst_n(lrst_n_reg),
    .d({bus_swap_select, chan_b_power_down, chan_b_output_disable,
        chan_a_power_down, chan_a_output_disable}),
    .q(pin_sync)
  );

  dop_sync #(.W(`DOP_CTRL_W), .INIT(`DOP_CTRL_RST)) u_ctrl_sync (
    .clk(chan_b_sample_clock),
    .rst_n(lrst_n_reg),
    .d(ctrl_reg),
    .q(ctrl_sync)
  );

  // status bits are independent levels, so a bit-wise crossing is enough
  dop_sync #(.W(`DOP_STAT_W), .INIT(`DOP_STAT_RST)) u_stat_sync (
    .clk(clk),
    .rst_n(nrst),
    .d(stat_link_reg),
    .q(stat_sync)
  );

  // ******************************************************************
  // channel control
  // ******************************************************************
  dop_pins_t pins_a, pins_b;
  dop_mode_t mode_a, mode_b;
  logic drive_a, drive_b, valid_a, valid_b;
  logic swap_s;

  // each channel sees only its own pins; software may force a disable
  assign pins_a.power_down = pin_sync[1];
  assign pins_a.output_disable = pin_sync[0] | ctrl_sync[`DOP_CTRL_FDIS_A];
  assign pins_b.power_down = pin_sync[3];
  assign pins_b.output_disable = pin_sync[2] | ctrl_sync[`DOP_CTRL_FDIS_B];
  assign swap_s = pin_sync[4];

  dop_chan #(.NAP_CYC(NAP_RECOV_CYC), .SLEEP_CYC(SLEEP_RECOV_CYC), .CW(16)) u_chan_a (
    .lclk(chan_b_sample_clock),
    .lrst_n(lrst_n_reg),
    .pins(pins_a),
    .mode(mode_a),
    .drive_en(drive_a),
    .data_valid(valid_a)
  );

  dop_chan #(.NAP_CYC(NAP_RECOV_CYC), .SLEEP_CYC(SLEEP_RECOV_CYC), .CW(16)) u_chan_b (
    .lclk(chan_b_sample_clock),
    .lrst_n(lrst_n_reg),
    .pins(pins_b),
    .mode(mode_b),
    .drive_en(drive_b),
    .data_valid(valid_b)
  );

  // ******************************************************************
  // output stage
  // ******************************************************************
  logic [DW-1:0] bus_a_reg, bus_a_next, bus_b_reg, bus_b_next;
  logic bus_a_oe_reg, bus_a_oe_next, bus_b_oe_reg, bus_b_oe_next;
  logic of_reg, of_next, of_oe_reg, of_oe_next;
  logic dr_en_reg, dr_en_next;

  always_comb begin
    if (swap_s) begin
      bus_a_next = chan_a_result.data;
      bus_a_oe_next = drive_a;
      bus_b_next = chan_b_result.data;
      bus_b_oe_next = drive_b;
    end else begin
      bus_a_next = chan_b_result.data;
      bus_a_oe_next = drive_b;
      bus_b_next = chan_a_result.data;
      bus_b_oe_next = drive_a;
    end
    // a floated bus is also parked low so nothing toggles behind it
    if (!bus_a_oe_next) begin
      bus_a_next = '0;
    end
    if (!bus_b_oe_next) begin
      bus_b_next = '0;
    end
    // one flag for both channels, gated by channel A alone
    of_next = chan_a_result.over | chan_b_result.over;
    of_oe_next = drive_a;
    if (!of_oe_next) begin
      of_next = 1'b0;
    end
    dr_en_next = (mode_b == MODE_NORMAL);
    stat_link_next = '0;
    stat_link_next[`DOP_STAT_NAP_A] = (mode_a == MODE_NAP);
    stat_link_next[`DOP_STAT_SLEEP_A] = (mode_a == MODE_SLEEP);
    stat_link_next[`DOP_STAT_VALID_A] = valid_a;
    stat_link_next[`DOP_STAT_NAP_B] = (mode_b == MODE_NAP);
    stat_link_next[`DOP_STAT_SLEEP_B] = (mode_b == MODE_SLEEP);
    stat_link_next[`DOP_STAT_VALID_B] = valid_b;
  end

  always_ff @(posedge chan_b_sample_clock) begin
    if (!lrst_n_reg) begin
      bus_a_reg <= '0;
      bus_b_reg <= '0;
      bus_a_oe_reg <= 1'b0;
      bus_b_oe_reg <= 1'b0;
      of_reg <= 1'b0;
      of_oe_reg <= 1'b0;
      dr_en_reg <= 1'b0;
      stat_link_reg <= `DOP_STAT_RST;
    end else begin
      bus_a_reg <= bus_a_next;
      bus_b_reg <= bus_b_next;
      bus_a_oe_reg <= bus_a_oe_next;
      bus_b_oe_reg <= bus_b_oe_next;
      of_reg <= of_next;
      of_oe_reg <= of_oe_next;
      dr_en_reg <= dr_en_next;
      stat_link_reg <= stat_link_next;
    end
  end

  assign bus_a_data = bus_a_reg;
  assign bus_a_data_oe = bus_a_oe_reg;
  assign bus_b_data = bus_b_reg;
  assign bus_b_data_oe = bus_b_oe_reg;
  assign range_overflow_flag = of_reg;
  assign range_overflow_flag_oe = of_oe_reg;

  // ******************************************************************
  // data ready clock
  // ******************************************************************
  // a rising-edge toggle and a falling-edge follower; their difference is
  // a copy of the sample clock one flop delay late, falling mid-way between
  // bus updates; the xor is the only output not taken from a single flop
  logic dr_pos_reg, dr_pos_next, dr_neg_reg;

  always_comb begin
    dr_pos_next = dr_pos_reg;
    if (dr_en_reg) begin
      dr_pos_next = ~dr_pos_reg;
    end
  end

  always_ff @(posedge chan_b_sample_clock) begin
    if (!lrst_n_reg) begin
      dr_pos_reg <= 1'b0;
    end else begin
      dr_pos_reg <= dr_pos_next;
    end
  end

  always_ff @(negedge chan_b_sample_clock) begin
    if (!lrst_n_reg) begin
      dr_neg_reg <= 1'b0;
    end else begin
      dr_neg_reg <= dr_pos_reg;
    end
  end

  assign data_ready_clock = dr_pos_reg ^ dr_neg_reg;
  assign data_ready_clock_oe = dr_en_reg;

endmodule : dop_top

//--- tb/dop_props.sv
// port checker for the dual-channel output and power control block
// assumes: bound into dop_top by tb_top; link clock runs through reset
`timescale 1ns/10ps
`include "dop_defs.svh"

module dop_props (
  input wire logic nrst,
  input wire logic chan_b_sample_clock,
  input wire logic chan_a_power_down,
  input wire logic chan_a_output_disable,
  input wire logic chan_b_power_down,
  input wire logic bus_swap_select,
  input wire dop_pkg::dop_sample_t chan_a_result,
  input wire dop_pkg::dop_sample_t chan_b_result,
  input wire logic [`DOP_DATA_W-1:0] bus_a_data,
  input wire logic bus_a_data_oe,
  input wire logic bus_b_data_oe,
  input wire logic range_overflow_flag,
  input wire logic range_overflow_flag_oe,
  input wire logic data_ready_clock_oe
);
  import dop_pkg::*;
  // pins need ~6 link edges to reach the outputs, so levels are held 8
  default clocking @(posedge chan_b_sample_clock); endclocking
  default disable iff (!nrst);
  // ****************************************************************
  // assertions
  // ****************************************************************
  AST_A_DIS_FLOAT: assert property (
    (chan_a_output_disable && bus_swap_select) [*8] |-> !bus_a_data_oe)
    else $error("bus a driven while channel a disabled");
  AST_A_DIS_SWAP: assert property (
    (chan_a_output_disable && !bus_swap_select) [*8] |-> !bus_b_data_oe)
    else $error("bus b driven while swapped channel a disabled");
  AST_OVF_DIS: assert property (
    chan_a_output_disable [*8] |-> !range_overflow_flag_oe)
    else $error("overflow flag driven while channel a disabled");
  AST_A_PD_FLOAT: assert property (
    (chan_a_power_down && bus_swap_select) [*8] |-> !bus_a_data_oe)
    else $error("bus a driven while channel a powered down");
  // bus b carries channel b only while the swap select is high
  AST_B_PD_CLK: assert property (
    (chan_b_power_down && bus_swap_select) [*8] |-> !data_ready_clock_oe && !bus_b_data_oe)
    else $error("channel b outputs driven while powered down");
  AST_STRAIGHT: assert property (
    bus_swap_select [*8] ##0 bus_a_data_oe |-> bus_a_data == $past(chan_a_result.data))
    else $error("bus a does not carry channel a");
  AST_CROSSED: assert property (
    !bus_swap_select [*8] ##0 bus_a_data_oe |-> bus_a_data == $past(chan_b_result.data))
    else $error("bus a does not carry channel b when swapped");
  AST_OVF_OR: assert property (
    range_overflow_flag_oe |->
      range_overflow_flag == ($past(chan_a_result.over) | $past(chan_b_result.over)))
    else $error("overflow flag is not the or of both channels");
  // ****************************************************************
  // covers
  // ****************************************************************
  COV_STRAIGHT: cover property (bus_swap_select && bus_a_data_oe);
  COV_CROSSED: cover property (!bus_swap_select && bus_a_data_oe);
  COV_OVF: cover property (range_overflow_flag_oe && range_overflow_flag);
endmodule : dop_props

//--- tb/dop_far_end.sv
// capturing logic model: latches both buses on the data ready clock fall
// assumes: wires without a driver show the inverse of the last driven value
`timescale 1ns/10ps
`include "dop_defs.svh"

module dop_far_end (
  input wire logic data_ready_clock,
  input wire logic data_ready_clock_oe,
  input wire logic [`DOP_DATA_W-1:0] bus_a_data,
  input wire logic bus_a_data_oe,
  input wire logic [`DOP_DATA_W-1:0] bus_b_data,
  input wire logic bus_b_data_oe,
  output logic [`DOP_DATA_W-1:0] cap_a,
  output logic [`DOP_DATA_W-1:0] cap_b
);
  logic [`DOP_DATA_W-1:0] last_a = '0;
  logic [`DOP_DATA_W-1:0] last_b = '0;
  always @* if (bus_a_data_oe) last_a = bus_a_data;
  always @* if (bus_b_data_oe) last_b = bus_b_data;
  // floated bus must not look like stale data
  always @(negedge data_ready_clock) begin
    if (data_ready_clock_oe) begin
      cap_a <= bus_a_data_oe ? bus_a_data : ~last_a;
      cap_b <= bus_b_data_oe ? bus_b_data : ~last_b;
    end
  end
endmodule : dop_far_end

//--- tb/tb_top.sv
// self-checking bench for dop_top with an apb master and the capturing model
// assumes: recovery counts shortened; results held steady around checks
`timescale 1ns/10ps
`include "dop_defs.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("Error at %0t: got %h expected %h", $time, g, e); end end

module tb_top;
  import dop_pkg::*;
  logic clk = 0, lclk = 0, nrst = 0;
  logic pd_a = 0, dis_a = 0, pd_b = 0, dis_b = 0, swap = 1;
  dop_apb_req_t apb_req = '0;
  dop_apb_rsp_t apb_rsp;
  dop_sample_t res_a = '0, res_b = '0;
  logic [9:0] bus_a, bus_b, cap_a, cap_b;
  logic oe_a, oe_b, ovf, ovf_oe, drc, drc_oe, err;
  logic [31:0] rd;
  int fail_count = 0, num_checks = 0, cyc = 0;
  always #5 clk = ~clk;
  // odd offset staggers the link clock; every fifth link edge, from 35 ns on, still lands on an apb clock edge
  initial begin #3; forever #32 lclk = ~lclk; end

  dop_top #(.SLEEP_RECOV_CYC(20), .NAP_RECOV_CYC(5)) uut (.clk(clk), .nrst(nrst),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .chan_b_sample_clock(lclk),
    .chan_a_power_down(pd_a), .chan_a_output_disable(dis_a), .chan_b_power_down(pd_b),
    .chan_b_output_disable(dis_b), .bus_swap_select(swap), .chan_a_result(res_a),
    .chan_b_result(res_b), .bus_a_data(bus_a), .bus_a_data_oe(oe_a), .bus_b_data(bus_b),
    .bus_b_data_oe(oe_b), .range_overflow_flag(ovf), .range_overflow_flag_oe(ovf_oe),
    .data_ready_clock(drc), .data_ready_clock_oe(drc_oe));
  dop_far_end far (.data_ready_clock(drc), .data_ready_clock_oe(drc_oe),
    .bus_a_data(bus_a), .bus_a_data_oe(oe_a), .bus_b_data(bus_b), .bus_b_data_oe(oe_b),
    .cap_a(cap_a), .cap_b(cap_b));

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
    @(posedge clk);
    apb_req.penable <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (apb_rsp.pready !== 1'b1 && n < 20);
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req <= '0;
  endtask : apb

  // pins are static levels held for many samples
  task automatic pins(input logic pa, da, pb, db, sw, input int n);
    @(posedge clk);
    {pd_a, dis_a, pd_b, dis_b, swap} <= {pa, da, pb, db, sw};
    repeat (n) @(posedge lclk);
  endtask : pins

  task automatic t_regs();
    apb(0, `DOP_CTRL_OFS, 0); `CHK(rd, 32'h0)
    apb(1, `DOP_STATUS_OFS, 32'hffff_ffff); `CHK(err, 1'b0)
    apb(0, 12'h008, 0); `CHK({err, rd}, 33'h1_0000_0000)
    apb(1, `DOP_CTRL_OFS, 32'h2); apb(0, `DOP_CTRL_OFS, 0); `CHK(rd, 32'h2)
    repeat (12) @(posedge lclk);
    `CHK({oe_a, oe_b}, 2'b10)
    apb(1, `DOP_CTRL_OFS, 32'h0);
  endtask : t_regs

  // straight and swapped routing, one shared clock, both buses driven
  task automatic t_route();
    @(posedge clk); res_a <= '{over: 1'b0, data: 10'h155}; res_b <= '{1'b0, 10'h0aa};
    pins(0, 0, 0, 0, 1, 12);
    `CHK({cap_a, cap_b}, {10'h155, 10'h0aa})
    `CHK(drc_oe, 1'b1)
    pins(0, 0, 0, 0, 0, 12);
    `CHK({cap_a, cap_b}, {10'h0aa, 10'h155})
    `CHK({oe_a, oe_b}, 2'b11)
  endtask : t_route

  task automatic t_ovf();
    @(posedge clk); res_b.over <= 1'b1; repeat (4) @(posedge lclk);
    `CHK({ovf, ovf_oe}, 2'b11)
    @(posedge clk); res_b.over <= 1'b0; res_a.over <= 1'b1; repeat (4) @(posedge lclk);
    `CHK({ovf, ovf_oe}, 2'b11)
    pins(0, 1, 0, 0, 1, 12);
    `CHK({ovf_oe, oe_a, oe_b}, 3'b001)
    `CHK(cap_b, 10'h0aa)
    pins(0, 1, 0, 0, 0, 12);
    `CHK({oe_a, oe_b}, 2'b10)
    @(posedge clk); res_a.over <= 1'b0;
  endtask : t_ovf

  task automatic t_nap();
    pins(0, 0, 1, 0, 1, 12);
    `CHK({oe_b, drc_oe, oe_a}, 3'b001)
    @(posedge clk); res_a.data <= 10'h3c3; repeat (4) @(posedge lclk);
    `CHK(bus_a, 10'h3c3)
    apb(0, `DOP_STATUS_OFS, 0); `CHK(rd, 32'h0c)
    pins(0, 0, 0, 0, 1, 16);
    apb(0, `DOP_STATUS_OFS, 0); `CHK(rd, 32'h24)
  endtask : t_nap

  task automatic t_sleep();
    pins(1, 1, 0, 0, 1, 12);
    `CHK({oe_a, ovf_oe, oe_b}, 3'b001)
    apb(0, `DOP_STATUS_OFS, 0); `CHK(rd, 32'h22)
    pins(0, 0, 0, 0, 1, 9);
    apb(0, `DOP_STATUS_OFS, 0); `CHK(rd, 32'h20)
    repeat (30) @(posedge lclk);
    apb(0, `DOP_STATUS_OFS, 0); `CHK(rd, 32'h24)
  endtask : t_sleep

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      fail_count++;
      summarize();
    end
  end

  initial begin
    // link side resets through a synchroniser, so reset spans link edges too
    repeat (3) @(posedge clk);
    repeat (6) @(posedge lclk);
    @(posedge clk); nrst <= 1'b1;
    repeat (40) @(posedge lclk);
    t_regs();
    t_route();
    t_ovf();
    t_nap();
    t_sleep();
    summarize();
  end
endmodule : tb_top

bind dop_top dop_props u_props (.nrst(nrst), .chan_b_sample_clock(chan_b_sample_clock),
  .chan_a_power_down(chan_a_power_down), .chan_a_output_disable(chan_a_output_disable),
  .chan_b_power_down(chan_b_power_down), .bus_swap_select(bus_swap_select),
  .chan_a_result(chan_a_result), .chan_b_result(chan_b_result), .bus_a_data(bus_a_data),
  .bus_a_data_oe(bus_a_data_oe), .bus_b_data_oe(bus_b_data_oe),
  .range_overflow_flag(range_overflow_flag), .range_overflow_flag_oe(range_overflow_flag_oe),
  .data_ready_clock_oe(data_ready_clock_oe));
